// ### inc/cycle_timing_params.svh
`ifndef CYCLE_TIMING_PARAMS_SVH
`define CYCLE_TIMING_PARAMS_SVH
`define CFG1_INDEX 4'h1
`define CYCLE_LEN_LSB 12
`define CYCLE_LEN_MSB 23
`define AVG_COUNT_LSB 0
`define AVG_COUNT_MSB 11
`define CFG1_RESET 24'h00_0000
`define CYCLES_PER_RESULT 4'h8
`define SLOW_REF_HZ 32768
`define CORE_CLK_HZ 40000000
`endif

// ### inc/cycle_timing_pkg.sv
package cycle_timing_pkg;
  typedef enum logic [3:0] {
    st_idle = 4'b0001,
    st_discharge = 4'b0010,
    st_recharge = 4'b0100,
    st_abandon = 4'b1000
  } phase_e;
  typedef struct packed {
    logic [11:0] cycle_length_count;
    logic [11:0] average_count;
  } cfg1_s;
  typedef struct packed {
    logic [23:0] data;
    logic [3:0] index;
    logic write;
  } reg_req_s;
  typedef struct packed {
    logic result_valid;
    logic timeout;
    logic [2:0] cycle_in_result;
    logic [11:0] results_done;
    logic average_done;
    logic cycle_active;
    logic recharging;
  } meas_status_s;
endpackage : cycle_timing_pkg

// ### logic/ref_tick_gen.sv
`timescale 1ns/10ps
`default_nettype none
`include "cycle_timing_params.svh"
// makes one reference tick enable: fast path divides by 1/2/4/8, slow path is a
// fractional accumulator yielding 32 kHz ticks from the core clock
module ref_tick_gen
  import cycle_timing_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset,
  input wire logic fast_tick,
  input wire logic [1:0] fast_clock_divider,
  input wire logic slow_reference_select,
  output logic ref_tick
);
  typedef struct packed {
    logic [2:0] div_cnt;
    logic [25:0] acc;
    logic tick;
  } div_state_s;
  localparam logic [25:0] slow_step = 26'(`SLOW_REF_HZ);
  localparam logic [25:0] core_hz = 26'(`CORE_CLK_HZ);
  div_state_s cur, next_cur;
  logic [2:0] div_top;
  always_comb begin
    next_cur = cur;
    next_cur.tick = 1'b0;
    div_top = 3'((4'h1 << fast_clock_divider) - 4'h1);
    if (slow_reference_select) begin
      if (cur.acc + slow_step >= core_hz) begin
        next_cur.acc = cur.acc + slow_step - core_hz;
        next_cur.tick = 1'b1;
      end else begin
        next_cur.acc = cur.acc + slow_step;
      end
    end else if (fast_tick) begin
      // divider applied to each reference period, so cycle = count x tref x div
      if (cur.div_cnt >= div_top) begin
        next_cur.div_cnt = 3'h0;
        next_cur.tick = 1'b1;
      end else begin
        next_cur.div_cnt = cur.div_cnt + 3'h1;
      end
    end
  end
  always_ff @(posedge core_clk) begin
    if (reset) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end
  assign ref_tick = cur.tick;
endmodule : ref_tick_gen
`default_nettype wire

// ### logic/cycle_timing_ctrl.sv
`timescale 1ns/10ps
`default_nettype none
`include "cycle_timing_params.svh"
module cycle_timing_ctrl
  import cycle_timing_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset,
  input wire reg_req_s reg_req,
  input wire logic reg_strobe,
  input wire logic fast_tick,
  input wire logic [1:0] fast_clock_divider,
  input wire logic slow_reference_select,
  input wire logic start,
  input wire logic comparator_trip,
  output logic [23:0] reg_rdata,
  output meas_status_s status,
  output logic [11:0] discharge_time,
  output logic discharge_valid,
  output logic recharge_on
);
  typedef struct packed {
    cfg1_s cfg;
    phase_e phase;
    logic [11:0] period_cnt;
    logic [11:0] dis_cnt;
    logic [2:0] cyc_idx;
    logic [11:0] avg_idx;
    logic [23:0] rdata;
    meas_status_s st;
    logic [11:0] dis_out;
    logic dis_valid;
    logic recharge;
  } ctrl_state_s;
  ctrl_state_s cur, next_cur;
  logic ref_tick;
  logic cycle_end;

  ref_tick_gen u_ref (
    .core_clk(core_clk),
    .reset(reset),
    .fast_tick(fast_tick),
    .fast_clock_divider(fast_clock_divider),
    .slow_reference_select(slow_reference_select),
    .ref_tick(ref_tick)
  );

  always_comb begin
    next_cur = cur;
    next_cur.st.result_valid = 1'b0;
    next_cur.st.average_done = 1'b0;
    next_cur.dis_valid = 1'b0;
    cycle_end = ref_tick && (cur.period_cnt + 12'h1 >= cur.cfg.cycle_length_count);
    if (reg_strobe && reg_req.index == `CFG1_INDEX) begin
      if (reg_req.write) begin
        next_cur.cfg = cfg1_s'(reg_req.data);
      end
      next_cur.rdata = cur.cfg;
    end
    unique case (cur.phase)
      st_idle: begin
        if (start) begin
          next_cur.phase = st_discharge;
          next_cur.period_cnt = 12'h0;
          next_cur.dis_cnt = 12'h0;
          next_cur.cyc_idx = 3'h0;
          next_cur.avg_idx = 12'h0;
          next_cur.st.timeout = 1'b0;
          next_cur.st.cycle_active = 1'b1;
        end
      end
      st_discharge: begin
        if (ref_tick) begin
          next_cur.period_cnt = cur.period_cnt + 12'h1;
          next_cur.dis_cnt = cur.dis_cnt + 12'h1;
        end
        if (comparator_trip) begin
          next_cur.phase = st_recharge;
          next_cur.recharge = 1'b1;
          next_cur.dis_out = cur.dis_cnt;
          next_cur.dis_valid = 1'b1;
        end else if (cycle_end) begin
          // threshold never reached: drop the whole measurement
          next_cur.phase = st_abandon;
          next_cur.st.timeout = 1'b1;
        end
      end
      st_recharge: begin
        if (ref_tick) begin
          next_cur.period_cnt = cur.period_cnt + 12'h1;
        end
        if (cycle_end) begin
          next_cur.recharge = 1'b0;
          next_cur.period_cnt = 12'h0;
          next_cur.dis_cnt = 12'h0;
          next_cur.phase = st_discharge;
          next_cur.cyc_idx = cur.cyc_idx + 3'h1;
          if (cur.cyc_idx == 3'(`CYCLES_PER_RESULT - 4'h1)) begin
            next_cur.st.result_valid = 1'b1;
            next_cur.avg_idx = cur.avg_idx + 12'h1;
            if (cur.avg_idx + 12'h1 >= cur.cfg.average_count) begin
              next_cur.st.average_done = 1'b1;
              next_cur.avg_idx = 12'h0;
            end
          end
        end
      end
      st_abandon: begin
        next_cur.phase = st_idle;
        next_cur.recharge = 1'b0;
        next_cur.st.cycle_active = 1'b0;
      end
      default: begin
        next_cur.phase = st_idle;
      end
    endcase
    next_cur.st.cycle_in_result = next_cur.cyc_idx;
    next_cur.st.results_done = next_cur.avg_idx;
    next_cur.st.recharging = next_cur.recharge;
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      cur <= '0;
      cur.cfg <= cfg1_s'(`CFG1_RESET);
      cur.phase <= st_idle;
    end else begin
      cur <= next_cur;
    end
  end

  assign reg_rdata = cur.rdata;
  assign status = cur.st;
  assign discharge_time = cur.dis_out;
  assign discharge_valid = cur.dis_valid;
  assign recharge_on = cur.recharge;
endmodule : cycle_timing_ctrl
`default_nettype wire

// ### tb/cycle_timing_monitor.sv
`timescale 1ns/10ps
`default_nettype none
module cycle_timing_monitor
  import cycle_timing_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset,
  input wire reg_req_s reg_req,
  input wire logic reg_strobe,
  input wire logic [23:0] reg_rdata,
  input wire meas_status_s status,
  input wire logic discharge_valid,
  input wire logic recharge_on
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);
  sequence cfg_wr; reg_strobe && reg_req.write && reg_req.index == 4'h1; endsequence
  sequence cfg_rd; reg_strobe && !reg_req.write && reg_req.index == 4'h1; endsequence
  chk_cfg_readback: assert property (cfg_wr ##1 !reg_strobe ##1 cfg_rd |=> reg_rdata == $past(reg_req.data, 3))
    else $error("readback wrong");
  chk_other_index: assert property (reg_strobe && reg_req.index != 4'h1 |=> $stable(reg_rdata))
    else $error("other index moved rdata");
  chk_rdata_hold: assert property (!reg_strobe |=> $stable(reg_rdata))
    else $error("rdata moved");
  chk_result_gap: assert property (status.result_valid |=> !status.result_valid [*7])
    else $error("results too close");
  chk_recharge_cycle: assert property (recharge_on |-> status.cycle_active)
    else $error("recharge outside cycle");
  chk_trip_recharge: assert property (discharge_valid |-> ##[0:1] recharge_on)
    else $error("no recharge after trip");
  chk_timeout_stop: assert property (status.timeout |-> !recharge_on)
    else $error("recharge after timeout");
  chk_timeout_idle: assert property ($rose(status.timeout) |=> !status.cycle_active)
    else $error("run after timeout");
endmodule : cycle_timing_monitor
bind cycle_timing_ctrl cycle_timing_monitor cycle_timing_monitor_inst (.core_clk(core_clk), .reset(reset),
  .reg_req(reg_req), .reg_strobe(reg_strobe), .reg_rdata(reg_rdata), .status(status),
  .discharge_valid(discharge_valid), .recharge_on(recharge_on));
`default_nettype wire

// ### tb/cycle_timing_ctrl_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module cycle_timing_ctrl_tb_top;
  import cycle_timing_pkg::*;
  logic core_clk = 0, reset = 1, stb = 0, sel = 0, start = 0, trip = 0;
  logic [1:0] div = 0;
  reg_req_s req = '0;
  logic [23:0] rdata;
  logic [11:0] dtime;
  logic dvalid, rchg;
  meas_status_s st;
  int miscompares = 0, samples_checked = 0;
  cycle_timing_ctrl cycle_timing_ctrl_inst (.core_clk(core_clk), .reset(reset), .reg_req(req), .reg_strobe(stb),
    .fast_tick(1'b1), .fast_clock_divider(div), .slow_reference_select(sel), .start(start),
    .comparator_trip(trip), .reg_rdata(rdata), .status(st), .discharge_time(dtime), .discharge_valid(dvalid),
    .recharge_on(rchg));
  initial forever #12.5 core_clk = ~core_clk;
  task automatic end_sim();
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : end_sim
  task automatic cmp(logic [23:0] got, logic [23:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("Error %0t: got %h want %h", $time, got, exp);
    end
  endtask : cmp
  task automatic cmp_gap(int got, int lo, int hi);
    cmp(24'(got >= lo && got <= hi), 24'h00_0001);
  endtask : cmp_gap
  task automatic step();
    @(posedge core_clk) #1;
  endtask : step
  task automatic reg_op(logic w, logic [3:0] idx, logic [23:0] d);
    req = '{data: d, index: idx, write: w};
    stb = 1;
    step();
    stb = 0;
    step();
  endtask : reg_op
  task automatic wait_rv(output int c);
    c = 0;
    do begin
      step();
      c++;
    end while (st.result_valid !== 1'b1 && c < 30000);
  endtask : wait_rv
  task automatic t_reg();
    reg_op(1, 4'h1, 24'hab_c123);
    cmp(rdata, 24'h00_0000);
    reg_op(0, 4'h1, 24'h00_0000);
    cmp(rdata, 24'hab_c123);
    reg_op(1, 4'h2, 24'h00_0fff);
    cmp(rdata, 24'hab_c123);
    $display("t_reg done");
  endtask : t_reg
  // gap between two results is eight cycles of len reference periods
  task automatic t_run(logic [1:0] d, logic s, logic [11:0] len, int lo, int hi);
    int c;
    reg_op(1, 4'h1, {len, 12'h001});
    div = d;
    sel = s;
    trip = 1;
    start = 1;
    step();
    start = 0;
    wait_rv(c);
    cmp(st.average_done, 1'b1);
    cmp(st.cycle_in_result, 3'h0);
    cmp(rchg, 1'b0);
    cmp(dtime, 12'h000);
    wait_rv(c);
    cmp_gap(c, lo, hi);
    trip = 0;
    c = 0;
    while (st.timeout !== 1'b1 && c < 30000) begin
      step();
      c++;
    end
    step();
    cmp(st.timeout, 1'b1);
    cmp(st.cycle_active, 1'b0);
    $display("t_run done");
  endtask : t_run
  initial begin
    repeat (8) @(posedge core_clk);
    #1 reset = 0;
    t_reg();
    for (int d = 0; d < 4; d++) t_run(d[1:0], 0, 12'h004, 32 << d, 32 << d);
    t_run(2'h0, 1, 12'h002, 19529, 19533);
    end_sim();
  end
  initial begin
    #2000000;
    miscompares++;
    end_sim();
  end
endmodule : cycle_timing_ctrl_tb_top
`default_nettype wire
